// ===== hw/acal_top.sv
// Per-channel offset, filter, limit alarms and slot-variable polling.
// Assumes samples arrive already scaled, Q16.16, on i_clk; APB master on i_clk.
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module acal_top #(
  parameter int unsigned NCH = 8,
  parameter int unsigned CW = $clog2(NCH),
  parameter int unsigned FILT_STEP_CYCLES = acal_pkg::FILT_STEP_CYC,
  parameter int unsigned HART_CYCLES = acal_pkg::HART_PERIOD_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [acal_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire logic i_smp_valid,
  input wire logic [CW-1:0] i_smp_ch,
  input wire logic [31:0] i_smp_val,
  output logic [NCH*acal_pkg::RANGE_W-1:0] o_range_sel,
  output logic o_scan_done,
  output logic o_fault_valid,
  output logic [CW-1:0] o_fault_ch,
  output logic [acal_pkg::NALM-1:0] o_fault_mask,
  output logic o_irq_valid,
  output logic [CW-1:0] o_irq_ch,
  output logic [acal_pkg::NALM-1:0] o_irq_mask,
  output logic o_hart_req_valid,
  input wire logic i_hart_req_ready,
  output logic [CW-1:0] o_hart_req_ch,
  output logic [7:0] o_hart_req_cmd,
  output logic [31:0] o_hart_req_data,
  input wire logic i_hart_rsp_valid,
  input wire logic [CW-1:0] i_hart_rsp_ch,
  input wire logic [31:0] i_hart_rsp_data
);
  import acal_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_LOAD, S_DIV, S_EVAL} acal_state_e;

  // Hysteresis compare; hi selects a high-side alarm
  function automatic logic alarm_eval(input logic act, input logic [31:0] v,
                                      input logic [31:0] lim, input logic [31:0] db,
                                      input logic hi);
    logic signed [33:0] vx;
    logic signed [33:0] lx;
    logic signed [33:0] dx;
    vx = {{2{v[31]}}, v};
    lx = {{2{lim[31]}}, lim};
    dx = {{2{db[31]}}, db};
    if (hi) begin
      return act ? (vx >= lx - dx) : (vx >= lx);
    end
    return act ? (vx <= lx + dx) : (vx <= lx);
  endfunction

  function automatic logic [32:0] sext33(input logic [31:0] v);
    return {v[31], v};
  endfunction

  // Configuration and state storage
  logic alarm_mode_reg;
  logic [NCH-1:0] filt_en_reg;
  logic [NCH-1:0] hart_en_reg;
  logic [NCH-1:0] slot_en_reg;
  logic [RANGE_W-1:0] range_reg [NCH];
  logic [31:0] offset_reg [NCH];
  logic [INTEG_W-1:0] integ_reg [NCH];
  logic [NALM-1:0] diag_en_reg [NCH];
  logic [NALM-1:0] fault_en_reg [NCH];
  logic [NALM-1:0] irq_en_reg [NCH];
  logic [31:0] slots_reg [NCH];
  logic [31:0] lim_reg [NCH][NALM];
  logic [31:0] db_reg [NCH][NALM];
  logic [31:0] raw_reg [NCH];
  logic [31:0] value_reg [NCH];
  logic [NALM-1:0] alarm_reg [NCH];
  logic [NALM-1:0] irqflag_reg [NCH];
  logic [31:0] hart_data_reg [NCH];

  // APB decode
  logic [ADDR_W-1:0] rel;
  logic [CW-1:0] ach;
  logic [5:0] roff;
  logic ctrl_hit;
  logic ch_hit;
  logic is_lim;
  logic is_db;
  logic [1:0] lidx;
  logic wr_en;
  logic [31:0] rd_data;
  logic [31:0] prdata_reg;
  logic pslverr_reg;

  assign rel = i_paddr - CH_BASE;
  assign ach = rel[CH_SHIFT +: CW];
  assign roff = rel[CH_SHIFT-1:0];
  assign ctrl_hit = i_paddr == CTRL_ADDR;
  assign ch_hit = i_paddr >= CH_BASE && i_paddr[1:0] == 2'h0 &&
                  rel[ADDR_W-1:CH_SHIFT] < (ADDR_W-CH_SHIFT)'(NCH);
  assign is_lim = roff >= R_LIM0 && roff < R_DB0;
  assign is_db = roff >= R_DB0 && roff < R_STATUS;
  assign lidx = is_lim ? 2'(roff[5:2] - R_LIM0[5:2]) : 2'(roff[5:2] - R_DB0[5:2]);
  assign wr_en = i_psel && i_penable && i_pwrite;

  always_comb begin
    rd_data = '0;
    if (ctrl_hit) begin
      rd_data[CTRL_ALM_BIT] = alarm_mode_reg;
    end else if (ch_hit) begin
      case (roff)
        R_CFG: begin
          rd_data[CFG_FILT_BIT] = filt_en_reg[ach];
          rd_data[CFG_HART_BIT] = hart_en_reg[ach];
          rd_data[CFG_SLOT_BIT] = slot_en_reg[ach];
          rd_data[CFG_RANGE_LSB +: RANGE_W] = range_reg[ach];
        end
        R_OFFSET: rd_data = offset_reg[ach];
        R_INTEG: rd_data[INTEG_W-1:0] = integ_reg[ach];
        R_ENABLES: begin
          rd_data[EN_DIAG_LSB +: NALM] = diag_en_reg[ach];
          rd_data[EN_FAULT_LSB +: NALM] = fault_en_reg[ach];
          rd_data[EN_IRQ_LSB +: NALM] = irq_en_reg[ach];
        end
        R_SLOTS: rd_data = slots_reg[ach];
        // Status word: diagnostic-enabled alarms plus interrupt-only flags
        R_STATUS: rd_data[NALM-1:0] = (alarm_reg[ach] & diag_en_reg[ach]) |
                                      irqflag_reg[ach];
        R_VALUE: rd_data = value_reg[ach];
        R_HART_DATA: rd_data = hart_data_reg[ach];
        default: begin
          if (is_lim) begin
            rd_data = lim_reg[ach][lidx];
          end else if (is_db) begin
            rd_data = db_reg[ach][lidx];
          end
        end
      endcase
    end
  end

  // Read data captured in the setup phase, so the access phase ends at once
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prdata_reg <= '0;
      pslverr_reg <= 1'b0;
    end else if (i_psel && !i_penable) begin
      prdata_reg <= rd_data;
      pslverr_reg <= !(ctrl_hit || ch_hit);
    end
  end

  assign o_pready = 1'b1;
  assign o_prdata = prdata_reg;
  assign o_pslverr = pslverr_reg;

  // Software-written configuration
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      alarm_mode_reg <= 1'b0;
      filt_en_reg <= '0;
      hart_en_reg <= '0;
      slot_en_reg <= '0;
      for (int c = 0; c < NCH; c++) begin
        range_reg[c] <= RANGE_RST;
        offset_reg[c] <= OFFSET_RST;
        integ_reg[c] <= INTEG_RST;
        diag_en_reg[c] <= '0;
        fault_en_reg[c] <= '0;
        irq_en_reg[c] <= '0;
        slots_reg[c] <= {NALM{SLOT_CODE_RST}};
        for (int a = 0; a < NALM; a++) begin
          lim_reg[c][a] <= LIMIT_RST;
          db_reg[c][a] <= DB_RST;
        end
      end
    end else if (wr_en) begin
      if (ctrl_hit) begin
        alarm_mode_reg <= i_pwdata[CTRL_ALM_BIT];
      end else if (ch_hit) begin
        case (roff)
          R_CFG: begin
            filt_en_reg[ach] <= i_pwdata[CFG_FILT_BIT];
            hart_en_reg[ach] <= i_pwdata[CFG_HART_BIT];
            slot_en_reg[ach] <= i_pwdata[CFG_SLOT_BIT];
            range_reg[ach] <= i_pwdata[CFG_RANGE_LSB +: RANGE_W];
          end
          R_OFFSET: offset_reg[ach] <= i_pwdata;
          R_INTEG: integ_reg[ach] <= i_pwdata[INTEG_W-1:0];
          R_ENABLES: begin
            diag_en_reg[ach] <= i_pwdata[EN_DIAG_LSB +: NALM];
            fault_en_reg[ach] <= i_pwdata[EN_FAULT_LSB +: NALM];
            irq_en_reg[ach] <= i_pwdata[EN_IRQ_LSB +: NALM];
          end
          R_SLOTS: slots_reg[ach] <= i_pwdata;
          default: begin
            if (is_lim) begin
              lim_reg[ach][lidx] <= i_pwdata;
            end else if (is_db) begin
              db_reg[ach][lidx] <= i_pwdata;
            end
          end
        endcase
      end
    end
  end

  // Range selection seen by the front end, registered like every data output except the constant o_hart_req_cmd
  logic [NCH*RANGE_W-1:0] range_sel_reg;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      range_sel_reg <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        range_sel_reg[i*RANGE_W +: RANGE_W] <=
          hart_en_reg[i] ? RANGE_4_20MA : range_reg[i];
      end
    end
  end

  assign o_range_sel = range_sel_reg;

  // Latest scaled sample per channel
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int c = 0; c < NCH; c++) begin
        raw_reg[c] <= '0;
      end
    end else if (i_smp_valid) begin
      raw_reg[i_smp_ch] <= i_smp_val;
    end
  end

  // Filter step tick
  logic [31:0] tick_cnt_reg;
  logic tick;
  assign tick = tick_cnt_reg == FILT_STEP_CYCLES - 1;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 32'h1;
    end
  end

  // Scan engine
  acal_state_e state_reg;
  logic [CW-1:0] ch_reg;
  logic [31:0] x_reg;
  logic [32:0] num_reg;
  logic [32:0] rem_reg;
  logic neg_reg;
  logic filt_reg;
  logic [5:0] div_cnt_reg;
  logic scan_done_reg;
  logic fault_valid_reg;
  logic [CW-1:0] fault_ch_reg;
  logic [NALM-1:0] fault_mask_reg;
  logic irq_valid_reg;
  logic [CW-1:0] irq_ch_reg;
  logic [NALM-1:0] irq_mask_reg;

  logic [31:0] x_sum;
  logic [32:0] diff;
  logic [32:0] rem_sh;
  logic [32:0] den;
  logic rem_ge;
  logic [32:0] sum33;
  logic [31:0] new_val;
  logic [NALM-1:0] alm_new;
  logic [NALM-1:0] rise;

  assign x_sum = raw_reg[ch_reg] + offset_reg[ch_reg];
  assign diff = sext33(x_sum) - sext33(value_reg[ch_reg]);
  assign rem_sh = {rem_reg[31:0], num_reg[32]};
  assign den = 33'(integ_reg[ch_reg]);
  assign rem_ge = rem_sh >= den;
  // y += (x - y) / T once per millisecond
  assign sum33 = sext33(value_reg[ch_reg]) + (neg_reg ? -num_reg : num_reg);
  assign new_val = filt_reg ? sum33[31:0] : x_reg;

  always_comb begin
    for (int a = 0; a < NALM; a++) begin
      alm_new[a] = alarm_mode_reg &&
                   alarm_eval(alarm_reg[ch_reg][a], new_val, lim_reg[ch_reg][a],
                              db_reg[ch_reg][a], a < ALM_L);
    end
  end
  assign rise = alm_new & ~alarm_reg[ch_reg];

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= S_IDLE;
      ch_reg <= '0;
      x_reg <= '0;
      num_reg <= '0;
      rem_reg <= '0;
      neg_reg <= 1'b0;
      filt_reg <= 1'b0;
      div_cnt_reg <= '0;
      scan_done_reg <= 1'b0;
      fault_valid_reg <= 1'b0;
      fault_ch_reg <= '0;
      fault_mask_reg <= '0;
      irq_valid_reg <= 1'b0;
      irq_ch_reg <= '0;
      irq_mask_reg <= '0;
      for (int c = 0; c < NCH; c++) begin
        value_reg[c] <= '0;
        alarm_reg[c] <= '0;
        irqflag_reg[c] <= '0;
      end
    end else begin
      scan_done_reg <= 1'b0;
      fault_valid_reg <= 1'b0;
      irq_valid_reg <= 1'b0;
      unique case (state_reg)
        S_IDLE: begin
          if (tick) begin
            ch_reg <= '0;
            state_reg <= S_LOAD;
          end
        end
        S_LOAD: begin
          x_reg <= x_sum;
          neg_reg <= diff[32];
          num_reg <= diff[32] ? -diff : diff;
          rem_reg <= '0;
          div_cnt_reg <= '0;
          filt_reg <= filt_en_reg[ch_reg] && integ_reg[ch_reg] != INTEG_RST;
          if (filt_en_reg[ch_reg] && integ_reg[ch_reg] != INTEG_RST) begin
            state_reg <= S_DIV;
          end else begin
            state_reg <= S_EVAL;
          end
        end
        S_DIV: begin
          rem_reg <= rem_ge ? rem_sh - den : rem_sh;
          num_reg <= {num_reg[31:0], rem_ge};
          div_cnt_reg <= div_cnt_reg + 6'h1;
          if (div_cnt_reg == 6'(DIV_STEPS - 1)) begin
            state_reg <= S_EVAL;
          end
        end
        S_EVAL: begin
          value_reg[ch_reg] <= new_val;
          alarm_reg[ch_reg] <= alm_new;
          // Interrupt-only status lasts until this channel's next scan
          irqflag_reg[ch_reg] <= rise & irq_en_reg[ch_reg] & ~diag_en_reg[ch_reg];
          fault_valid_reg <= |(rise & fault_en_reg[ch_reg]);
          fault_ch_reg <= ch_reg;
          fault_mask_reg <= rise & fault_en_reg[ch_reg];
          irq_valid_reg <= |(rise & irq_en_reg[ch_reg]);
          irq_ch_reg <= ch_reg;
          irq_mask_reg <= rise & irq_en_reg[ch_reg];
          if (ch_reg == CW'(NCH - 1)) begin
            scan_done_reg <= 1'b1;
            state_reg <= S_IDLE;
          end else begin
            ch_reg <= ch_reg + CW'(1);
            state_reg <= S_LOAD;
          end
        end
      endcase
    end
  end

  assign o_scan_done = scan_done_reg;
  assign o_fault_valid = fault_valid_reg;
  assign o_fault_ch = fault_ch_reg;
  assign o_fault_mask = fault_mask_reg;
  assign o_irq_valid = irq_valid_reg;
  assign o_irq_ch = irq_ch_reg;
  assign o_irq_mask = irq_mask_reg;

  // Slot-variable polling
  logic [31:0] hart_cnt_reg;
  logic hart_tick;
  logic [NCH-1:0] hart_pend_reg;
  logic [NCH-1:0] hart_set;
  logic [NCH-1:0] hart_clr;
  logic [CW-1:0] pick_ch;
  logic pick_any;
  logic hart_load;
  logic hreq_valid_reg;
  logic [CW-1:0] hreq_ch_reg;
  logic [31:0] hreq_data_reg;

  assign hart_tick = hart_cnt_reg == HART_CYCLES - 1;
  assign hart_set = hart_tick ? (hart_en_reg & slot_en_reg) : '0;

  always_comb begin
    pick_ch = '0;
    pick_any = 1'b0;
    for (int c = NCH - 1; c >= 0; c--) begin
      if (hart_pend_reg[c]) begin
        pick_ch = CW'(c);
        pick_any = 1'b1;
      end
    end
  end

  assign hart_load = (!hreq_valid_reg || i_hart_req_ready) && pick_any;
  assign hart_clr = hart_load ? (NCH'(1) << pick_ch) : '0;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      hart_cnt_reg <= '0;
    end else begin
      hart_cnt_reg <= hart_tick ? '0 : hart_cnt_reg + 32'h1;
    end
  end

  // A new period that lands on a pick keeps the channel pending
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      hart_pend_reg <= '0;
    end else begin
      hart_pend_reg <= (hart_pend_reg & ~hart_clr) | hart_set;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      hreq_valid_reg <= 1'b0;
      hreq_ch_reg <= '0;
      hreq_data_reg <= '0;
    end else if (hart_load) begin
      hreq_valid_reg <= 1'b1;
      hreq_ch_reg <= pick_ch;
      hreq_data_reg <= slots_reg[pick_ch];
    end else if (i_hart_req_ready) begin
      hreq_valid_reg <= 1'b0;
    end
  end

  assign o_hart_req_valid = hreq_valid_reg;
  assign o_hart_req_ch = hreq_ch_reg;
  assign o_hart_req_cmd = HART_CMD_SLOT_VARS;
  assign o_hart_req_data = hreq_data_reg;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int c = 0; c < NCH; c++) begin
        hart_data_reg[c] <= '0;
      end
    end else if (i_hart_rsp_valid) begin
      hart_data_reg[i_hart_rsp_ch] <= i_hart_rsp_data;
    end
  end
endmodule

`default_nettype wire

// ===== shared/acal_pkg.sv
// Constants shared by the analog channel alarm logic.
// Assumes a 25 MHz system clock and a 32-bit APB register bus.
package acal_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned FILT_STEP_MS = 1;
  localparam int unsigned FILT_STEP_CYC = CLK_HZ / MS_PER_S * FILT_STEP_MS;
  localparam int unsigned HART_PERIOD_MS = 1000;
  localparam int unsigned HART_PERIOD_CYC = CLK_HZ / MS_PER_S * HART_PERIOD_MS;

  // Alarm slots
  localparam int NALM = 4;
  localparam int ALM_HH = 0;
  localparam int ALM_H = 1;
  localparam int ALM_L = 2;
  localparam int ALM_LL = 3;

  // Widths
  localparam int RANGE_W = 3;
  localparam int INTEG_W = 16;
  localparam int ADDR_W = 12;
  localparam int DIV_STEPS = 33;

  // Address map
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] CH_BASE = 12'h200;
  localparam int CH_SHIFT = 6;
  localparam logic [5:0] R_CFG = 6'h00;
  localparam logic [5:0] R_OFFSET = 6'h04;
  localparam logic [5:0] R_INTEG = 6'h08;
  localparam logic [5:0] R_ENABLES = 6'h0C;
  localparam logic [5:0] R_SLOTS = 6'h10;
  localparam logic [5:0] R_LIM0 = 6'h14;
  localparam logic [5:0] R_DB0 = 6'h24;
  localparam logic [5:0] R_STATUS = 6'h34;
  localparam logic [5:0] R_VALUE = 6'h38;
  localparam logic [5:0] R_HART_DATA = 6'h3C;

  // Field positions
  localparam int CTRL_ALM_BIT = 0;
  localparam int CFG_FILT_BIT = 0;
  localparam int CFG_HART_BIT = 1;
  localparam int CFG_SLOT_BIT = 2;
  localparam int CFG_RANGE_LSB = 4;
  localparam int EN_DIAG_LSB = 0;
  localparam int EN_FAULT_LSB = 4;
  localparam int EN_IRQ_LSB = 8;

  // Range codes, reset values and the HART command code
  localparam logic [RANGE_W-1:0] RANGE_RST = 3'h0;
  localparam logic [RANGE_W-1:0] RANGE_4_20MA = 3'h6;
  localparam logic [31:0] OFFSET_RST = 32'h0;
  localparam logic [31:0] LIMIT_RST = 32'h0;
  localparam logic [31:0] DB_RST = 32'h0;
  localparam logic [INTEG_W-1:0] INTEG_RST = 16'h0;
  localparam logic [7:0] SLOT_CODE_RST = 8'h01;
  localparam logic [7:0] HART_CMD_SLOT_VARS = 8'h21;
endpackage

// ===== dv/acal_asserts.sv
// Checker on the event, range and request ports of acal_top.
// Assumes one clock domain and a bind onto every acal_top instance.
`timescale 1ns/1ns
`default_nettype none
module acal_asserts
  import acal_pkg::*;
#(
  parameter int unsigned NCH = 8,
  parameter int unsigned CW = 3
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [NCH*acal_pkg::RANGE_W-1:0] o_range_sel,
  input wire logic o_scan_done,
  input wire logic o_fault_valid,
  input wire logic [CW-1:0] o_fault_ch,
  input wire logic [acal_pkg::NALM-1:0] o_fault_mask,
  input wire logic o_irq_valid,
  input wire logic [CW-1:0] o_irq_ch,
  input wire logic [acal_pkg::NALM-1:0] o_irq_mask,
  input wire logic o_hart_req_valid,
  input wire logic i_hart_req_ready,
  input wire logic [CW-1:0] o_hart_req_ch,
  input wire logic [7:0] o_hart_req_cmd,
  input wire logic [31:0] o_hart_req_data
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  AST_HART_CMD: assert property (
    o_hart_req_valid |-> o_hart_req_cmd == HART_CMD_SLOT_VARS) else $error("bad hart cmd");
  AST_HART_RANGE: assert property (
    o_hart_req_valid |-> o_range_sel[o_hart_req_ch*RANGE_W +: RANGE_W] == RANGE_4_20MA)
    else $error("hart channel not 4-20mA");
  AST_HART_HOLD: assert property (
    o_hart_req_valid && !i_hart_req_ready |=> o_hart_req_valid && $stable(o_hart_req_data)
    && $stable(o_hart_req_ch)) else $error("hart request dropped");
  AST_FAULT_MASK: assert property (
    o_fault_valid |-> o_fault_mask != 4'h0 && o_fault_ch < NCH) else $error("empty fault");
  AST_FAULT_GAP: assert property (
    o_fault_valid |=> !o_fault_valid) else $error("fault pulse too long");
  AST_IRQ_MASK: assert property (
    o_irq_valid |-> o_irq_mask != 4'h0 && o_irq_ch < NCH) else $error("empty irq");
  AST_IRQ_GAP: assert property (
    o_irq_valid |=> !o_irq_valid) else $error("irq pulse too long");
  AST_SCAN_GAP: assert property (
    o_scan_done |=> (!o_scan_done) [*8]) else $error("scans too close");
endmodule
bind acal_top acal_asserts #(.NCH(NCH), .CW(CW)) u_acal_asserts (
  .i_clk(i_clk), .i_rst(i_rst), .o_range_sel(o_range_sel), .o_scan_done(o_scan_done),
  .o_fault_valid(o_fault_valid), .o_fault_ch(o_fault_ch), .o_fault_mask(o_fault_mask),
  .o_irq_valid(o_irq_valid), .o_irq_ch(o_irq_ch), .o_irq_mask(o_irq_mask),
  .o_hart_req_valid(o_hart_req_valid), .i_hart_req_ready(i_hart_req_ready),
  .o_hart_req_ch(o_hart_req_ch), .o_hart_req_cmd(o_hart_req_cmd),
  .o_hart_req_data(o_hart_req_data)
);
`default_nettype wire

// ===== dv/acal_hart_model.sv
// HART engine stand-in: takes slot-variable requests, answers each one.
// Assumes the request handshake of acal_top on the same clock.
`timescale 1ns/1ns
`default_nettype none
module acal_hart_model #(
  parameter int unsigned CW = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_slow,
  input wire logic i_req_valid,
  input wire logic [CW-1:0] i_req_ch,
  input wire logic [31:0] i_req_data,
  output logic o_req_ready = 1'h0,
  output logic o_rsp_valid = 1'h0,
  output logic [CW-1:0] o_rsp_ch = '0,
  output logic [31:0] o_rsp_data = 32'h0,
  output logic [CW-1:0] o_got_ch = '0,
  output logic [31:0] o_got_data = 32'h0,
  output logic [7:0] o_got_cnt = 8'h00
);
  logic [2:0] wait_reg = 3'h0;
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_req_ready <= 1'h0;
      o_rsp_valid <= 1'h0;
      o_got_cnt <= 8'h00;
      wait_reg <= 3'h0;
    end else if (i_req_valid && o_req_ready) begin
      o_req_ready <= 1'h0;
      wait_reg <= 3'h0;
      o_got_cnt <= o_got_cnt + 8'h01;
      o_got_ch <= i_req_ch;
      o_got_data <= i_req_data;
      o_rsp_valid <= 1'h1;
      o_rsp_ch <= i_req_ch;
      o_rsp_data <= ~i_req_data;
    end else begin
      // Idle reply lines toggle so stale data never looks valid
      o_rsp_valid <= 1'h0;
      o_rsp_ch <= ~o_rsp_ch;
      o_rsp_data <= ~o_rsp_data;
      if (i_req_valid && wait_reg == (i_slow ? 3'h5 : 3'h0)) begin
        o_req_ready <= 1'h1;
      end else if (i_req_valid) begin
        wait_reg <= wait_reg + 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/analog_channel_alarm_logic_tb.sv
// Bench for acal_top: APB tasks, sample driver, event monitor, HART model.
// Assumes acal_pkg, acal_hart_model and the bound checker compiled first.
`timescale 1ns/1ns
`default_nettype none
module analog_channel_alarm_logic_tb;
  import acal_pkg::*;
  localparam int unsigned NCH = 2;
  localparam int unsigned CW = 1;
  logic i_clk = 1'h0;
  logic i_rst = 1'h1;
  logic i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0, i_smp_valid = 1'h0, slow = 1'h0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, i_smp_val = 32'h0;
  logic [CW-1:0] i_smp_ch = '0;
  logic o_pready, o_pslverr, o_scan_done, o_fault_valid, o_irq_valid, o_hart_req_valid;
  logic [31:0] o_prdata, o_hart_req_data, rsp_data, got_data;
  logic [NCH*RANGE_W-1:0] o_range_sel;
  logic [CW-1:0] o_fault_ch, o_irq_ch, o_hart_req_ch, rsp_ch, got_ch;
  logic [3:0] o_fault_mask, o_irq_mask;
  logic [7:0] o_hart_req_cmd, got_cnt;
  logic ready, rsp_valid;
  logic [CW+3:0] flast, ilast;
  int fcnt = 0, icnt = 0, f0, i0, n_errors = 0, checks_done = 0;
  always #20 i_clk = ~i_clk;
  acal_top #(.NCH(NCH), .CW(CW), .FILT_STEP_CYCLES(100), .HART_CYCLES(50)) DUT (
    .i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
    .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_smp_valid(i_smp_valid),
    .i_smp_ch(i_smp_ch), .i_smp_val(i_smp_val), .o_range_sel(o_range_sel),
    .o_scan_done(o_scan_done), .o_fault_valid(o_fault_valid), .o_fault_ch(o_fault_ch),
    .o_fault_mask(o_fault_mask), .o_irq_valid(o_irq_valid), .o_irq_ch(o_irq_ch),
    .o_irq_mask(o_irq_mask), .o_hart_req_valid(o_hart_req_valid),
    .i_hart_req_ready(ready), .o_hart_req_ch(o_hart_req_ch),
    .o_hart_req_cmd(o_hart_req_cmd), .o_hart_req_data(o_hart_req_data),
    .i_hart_rsp_valid(rsp_valid), .i_hart_rsp_ch(rsp_ch), .i_hart_rsp_data(rsp_data)
  );
  acal_hart_model #(.CW(CW)) u_hart (
    .i_clk(i_clk), .i_rst(i_rst), .i_slow(slow), .i_req_valid(o_hart_req_valid),
    .i_req_ch(o_hart_req_ch), .i_req_data(o_hart_req_data), .o_req_ready(ready),
    .o_rsp_valid(rsp_valid), .o_rsp_ch(rsp_ch), .o_rsp_data(rsp_data),
    .o_got_ch(got_ch), .o_got_data(got_data), .o_got_cnt(got_cnt)
  );
  always @(posedge i_clk) begin
    if (o_fault_valid === 1'h1) begin
      fcnt <= fcnt + 1;
      flast <= {o_fault_ch, o_fault_mask};
    end
    if (o_irq_valid === 1'h1) begin
      icnt <= icnt + 1;
      ilast <= {o_irq_ch, o_irq_mask};
    end
  end
  function automatic logic [11:0] ra(input int ch, input logic [5:0] r);
    return CH_BASE + 12'(ch << CH_SHIFT) + {6'h00, r};
  endfunction
  function automatic logic [31:0] q(input int v);
    return 32'(v) << 16;
  endfunction
  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic to();
    n_errors++;
    $display("ERROR t=%0t wait timed out", $time);
    final_report();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    i_psel <= 1'h1;
    i_penable <= 1'h0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'h1;
    @(posedge i_clk);
    while (o_pready !== 1'h1 && n < 50) begin
      n++;
      @(posedge i_clk);
    end
    if (n >= 50) to();
    r = o_prdata;
    e = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
    @(posedge i_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'h1, a, d, r, e);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'h0, a, 32'h0, r, e);
    chk(r, exp);
  endtask
  task automatic wait_scan();
    int n;
    n = 0;
    @(posedge i_clk);
    while (o_scan_done !== 1'h1 && n < 1000) begin
      n++;
      @(posedge i_clk);
    end
    if (n >= 1000) to();
    @(posedge i_clk);
  endtask
  task automatic step(input int ch, input int v);
    wait_scan();
    f0 = fcnt;
    i0 = icnt;
    i_smp_valid <= 1'h1;
    i_smp_ch <= CW'(ch);
    i_smp_val <= q(v);
    @(posedge i_clk);
    i_smp_valid <= 1'h0;
    wait_scan();
  endtask
  task automatic alm(input int ch, input int v, input logic [3:0] st, input int nf,
                     input logic [3:0] fm, input int ni, input logic [3:0] im);
    step(ch, v);
    rdc(ra(ch, R_STATUS), {28'h0, st});
    chk(32'(fcnt - f0), 32'(nf));
    chk(32'(icnt - i0), 32'(ni));
    if (nf > 0) chk(32'(flast), 32'({CW'(ch), fm}));
    if (ni > 0) chk(32'(ilast), 32'({CW'(ch), im}));
  endtask
  task automatic wait_hart(input int k);
    int n;
    n = 0;
    while (int'(got_cnt) < k && n < 500) begin
      n++;
      @(posedge i_clk);
    end
    if (n >= 500) to();
  endtask
  initial begin
    logic [31:0] r;
    logic e;
    int y;
    repeat (12) @(posedge i_clk);
    i_rst <= 1'h0;
    @(posedge i_clk);
    rdc(CTRL_ADDR, 32'h0);
    rdc(ra(0, R_CFG), 32'h0);
    rdc(ra(0, R_OFFSET), 32'h0);
    rdc(ra(0, R_INTEG), 32'h0);
    rdc(ra(0, R_ENABLES), 32'h0);
    rdc(ra(1, R_SLOTS), 32'h01010101);
    apb(1'h0, 12'h100, 32'h0, r, e);
    chk(32'(e), 32'h1);
    chk(32'(o_range_sel), 32'h0);
    $display("test defaults done");
    wr(ra(1, R_CFG), 32'h1);
    step(1, 0);
    wr(ra(1, R_INTEG), 32'hA);
    step(1, 100);
    repeat (9) wait_scan();
    y = 0;
    repeat (10) y = y + ((100 << 16) - y) / 10;
    rdc(ra(1, R_VALUE), 32'(y));
    wr(ra(1, R_INTEG), 32'h0);
    step(1, 100);
    rdc(ra(1, R_VALUE), q(100));
    wr(ra(1, R_CFG), 32'h0);
    $display("test filter done");
    wr(ra(0, R_LIM0), q(100));
    wr(ra(0, R_LIM0 + 6'h04), q(50));
    wr(ra(0, R_LIM0 + 6'h08), q(-50));
    wr(ra(0, R_LIM0 + 6'h0C), q(-100));
    wr(ra(0, R_DB0 + 6'h04), q(10));
    wr(ra(0, R_DB0 + 6'h08), q(10));
    wr(ra(0, R_ENABLES), 32'hFF);
    alm(0, 60, 4'h0, 0, 4'h0, 0, 4'h0);
    wr(CTRL_ADDR, 32'h1);
    alm(0, 0, 4'h0, 0, 4'h0, 0, 4'h0);
    alm(0, 50, 4'h2, 1, 4'h2, 0, 4'h0);
    alm(0, 40, 4'h2, 0, 4'h0, 0, 4'h0);
    alm(0, 39, 4'h0, 0, 4'h0, 0, 4'h0);
    alm(0, 100, 4'h3, 1, 4'h3, 0, 4'h0);
    alm(0, -100, 4'hC, 1, 4'hC, 0, 4'h0);
    alm(0, -45, 4'h4, 0, 4'h0, 0, 4'h0);
    wr(ra(0, R_OFFSET), q(5));
    alm(0, -42, 4'h0, 0, 4'h0, 0, 4'h0);
    rdc(ra(0, R_VALUE), q(-37));
    $display("test alarms done");
    wr(ra(1, R_LIM0 + 6'h04), q(50));
    wr(ra(1, R_ENABLES), 32'h200);
    alm(1, 20, 4'h0, 0, 4'h0, 0, 4'h0);
    alm(1, 60, 4'h2, 0, 4'h0, 1, 4'h2);
    wait_scan();
    rdc(ra(1, R_STATUS), 32'h0);
    $display("test interrupt status done");
    wr(ra(1, R_SLOTS), 32'hA1B2C3D4);
    wr(ra(0, R_CFG), 32'h20);
    @(posedge i_clk);
    chk(32'(o_range_sel), 32'h02);
    wr(ra(1, R_CFG), 32'h26);
    @(posedge i_clk);
    chk(32'(o_range_sel), 32'h32);
    wait_hart(2);
    chk(got_data, 32'hA1B2C3D4);
    chk(32'(got_ch), 32'h1);
    slow <= 1'h1;
    wait_hart(4);
    rdc(ra(1, R_HART_DATA), 32'h5E4D3C2B);
    $display("test hart done");
    final_report();
  end
endmodule
`default_nettype wire
